// ---- hw/rsswk_top.sv ----
// Summary of operation
// - stop looks at request flags as they stood one instruction earlier, so a clear needs a nop gap.
// - three reset sources exist: the reset pin, the power detector and a stack overflow or underflow.
// - every reset loads pc 0000H and makes ports inputs; output latches clear only on pin or power reset.
// - pin or power reset in standby keeps memory and window register; data buffer clears to 0; system registers clear.
// - pin or power reset sets stack pointer 5H, timer request and timer enable to 1, pin status to pin level, rest 0.
// - stack reset sets stack pointer 5H, pin status to pin level, and every other control bit to 0.
// - shift register kept on standby pin or power reset; timer count clears on pin or power; modulo loads FFH always.
// - stop with an enabled request already set acts as a no-operation.
// - stop operand bit 3 allows wake by enabled requests; timer request never wakes; with zero only reset ends stop.
`timescale 1ns/100ps
`default_nettype none
module rsswk_top (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// reset sources
	input  wire logic        reset_pin_n_i,
	input  wire logic        power_reset_i,
	input  wire logic        stack_fault_i,
	// events and pins
	input  wire logic        int_pin_i,
	input  wire logic        int_edge_i,
	input  wire logic        serial_done_i,
	input  wire logic        timer_tick_i,
	input  wire logic        stop_exec_i,
	input  wire logic [3:0]  stop_operand_i,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// core view
	output logic [15:0]      pc_o,
	output logic [3:0]       stack_pointer_o,
	output logic             port_dir_out_o,
	output logic [3:0]       port_latch_o,
	output logic             stopped_o,
	output logic             core_run_o,
	output logic             irq_o
);
	import rsswk_pkg::*;

	// =====================================================
	// state
	rsswk_state_t state;
	rsswk_src_t   last_src;
	logic [10:0]  ctrl;
	logic [10:0]  ctrl_prev;
	logic [3:0]   stop_cond;
	logic [7:0]   timer_count;
	logic [7:0]   timer_modulo;
	logic [7:0]   serial_shift_reg;
	logic [7:0]   general_mem;
	logic [3:0]   window_reg;
	logic [3:0]   data_buffer;
	logic [IRQ_BITS-1:0] irq_stat;
	logic [IRQ_BITS-1:0] irq_mask;
	logic         int_pin_q;
	logic         in_standby;
	logic [7:0]   aw_q;
	logic [31:0]  w_q;
	logic [3:0]   ws_q;
	logic         aw_have;
	logic         w_have;
	logic         pin_rst;
	logic         pwr_rst;
	logic         any_rst;
	logic         wr_fire;
	logic         ctrl_wr;
	logic         pin_wake;
	logic         sio_wake;
	logic         req_pending;
	logic         stop_ignored;
	logic         stop_enter;
	logic         wait_done;
	logic [31:0]  ctrl_merged;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign pin_rst = !reset_pin_n_i;
	assign pwr_rst = power_reset_i;
	assign any_rst = pin_rst || pwr_rst || stack_fault_i;

	assign wr_fire = aw_have && w_have && !s_axi_bvalid;
	assign ctrl_wr = wr_fire && (aw_q == ADDR_CTRL);
	assign ctrl_merged = wmerge({21'h000000, ctrl}, w_q, ws_q);

	assign pin_wake = ctrl_prev[CTRL_PIN_IRQ] && ctrl_prev[CTRL_PIN_IE];
	assign sio_wake = ctrl_prev[CTRL_SIO_IRQ] && ctrl_prev[CTRL_SIO_IE];
	assign req_pending = pin_wake || sio_wake;
	assign stop_ignored = (state == RSSWK_RUN) && stop_exec_i && !any_rst && req_pending;
	assign stop_enter = (state == RSSWK_RUN) && stop_exec_i && !any_rst && !req_pending;
	assign wait_done = (state == RSSWK_WAIT) && (timer_count == timer_modulo) && timer_tick_i;

	// =====================================================
	// axi write channel
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h00000000;
			ws_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_have && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have <= 1'b1;
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_q <= ADDR_MEM && aw_q[1:0] == 2'h0 && aw_q != ADDR_STATE) ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// =====================================================
	// axi read channel
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					ADDR_CTRL: begin
						s_axi_rdata <= {21'h000000, ctrl};
					end
					ADDR_STATE: begin
						s_axi_rdata <= {16'h0000, 5'h00, state, 1'b0, int_pin_q, last_src, stack_pointer_o};
					end
					ADDR_STOP: begin
						s_axi_rdata <= {28'h0000000, stop_cond};
					end
					ADDR_IRQ_STAT: begin
						s_axi_rdata <= {29'h00000000, irq_stat};
					end
					ADDR_IRQ_MASK: begin
						s_axi_rdata <= {29'h00000000, irq_mask};
					end
					ADDR_TIMER: begin
						s_axi_rdata <= {16'h0000, timer_modulo, timer_count};
					end
					ADDR_MEM: begin
						s_axi_rdata <= {3'h0, port_dir_out_o, port_latch_o, data_buffer, window_reg, serial_shift_reg,
							general_mem};
					end
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// =====================================================
	// control bits
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl <= 11'h000;
			ctrl_prev <= 11'h000;
			int_pin_q <= 1'b0;
		end else begin
			ctrl_prev <= ctrl;
			int_pin_q <= int_pin_i;
			if (pin_rst || pwr_rst) begin
				ctrl <= 11'h000;
				ctrl[CTRL_TMR_EN] <= 1'b1;
				ctrl[CTRL_TMR_IRQ] <= 1'b1;
			end else if (stack_fault_i) begin
				ctrl <= 11'h000;
			end else begin
				if (ctrl_wr) begin
					ctrl <= ctrl_merged[10:0];
				end
				// set wins over clear
				if (int_edge_i) begin
					ctrl[CTRL_PIN_IRQ] <= 1'b1;
				end
				if (serial_done_i) begin
					ctrl[CTRL_SIO_IRQ] <= 1'b1;
				end
				if (timer_tick_i && ctrl[CTRL_TMR_EN] && timer_count == timer_modulo) begin
					ctrl[CTRL_TMR_IRQ] <= 1'b1;
				end
			end
		end
	end

	// =====================================================
	// stop and wake sequencer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= RSSWK_WAIT;
			stop_cond <= 4'h0;
			stopped_o <= 1'b0;
			core_run_o <= 1'b0;
			last_src <= RSSWK_SRC_NONE;
			in_standby <= 1'b0;
		end else begin
			if (any_rst) begin
				in_standby <= (state == RSSWK_STOP);
				last_src <= pin_rst ? RSSWK_SRC_PIN : (pwr_rst ? RSSWK_SRC_PWR : RSSWK_SRC_STK);
				// stack reset skips the stabilization wait
				state <= (pin_rst || pwr_rst) ? RSSWK_WAIT : RSSWK_RUN;
				stopped_o <= 1'b0;
				core_run_o <= !(pin_rst || pwr_rst);
			end else begin
				case (state)
					RSSWK_RUN: begin
						if (stop_enter) begin
							state <= RSSWK_STOP;
							stop_cond <= stop_operand_i;
							stopped_o <= 1'b1;
							core_run_o <= 1'b0;
						end
					end
					RSSWK_STOP: begin
						// wake only with operand bit set
						if (stop_cond[STOP_WAKE_BIT] && req_pending) begin
							state <= RSSWK_WAIT;
							stopped_o <= 1'b0;
						end
					end
					RSSWK_WAIT: begin
						if (wait_done) begin
							state <= RSSWK_RUN;
							core_run_o <= 1'b1;
						end
					end
					default: begin
						state <= RSSWK_RUN;
					end
				endcase
			end
		end
	end

	// =====================================================
	// timer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			timer_count <= TMR_CNT_RST;
			timer_modulo <= TMR_MOD_RST;
		end else begin
			if (any_rst) begin
				timer_modulo <= TMR_MOD_RST;
				timer_count <= (pin_rst || pwr_rst) ? TMR_CNT_RST : timer_count;
			end else begin
				if (wr_fire && aw_q == ADDR_TIMER && ws_q[1]) begin
					timer_modulo <= w_q[15:8];
				end
				if (state == RSSWK_STOP) begin
					timer_count <= TMR_CNT_RST;
				end else if (timer_tick_i && (ctrl[CTRL_TMR_EN] || state == RSSWK_WAIT)) begin
					timer_count <= (timer_count == timer_modulo) ? TMR_CNT_RST : timer_count + 8'h01;
				end
			end
		end
	end

	// =====================================================
	// core view and data storage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_o <= PC_RESET;
			stack_pointer_o <= SP_RESET;
			port_dir_out_o <= 1'b0;
			port_latch_o <= 4'h0;
			general_mem <= 8'h00;
			window_reg <= 4'h0;
			data_buffer <= 4'h0;
			serial_shift_reg <= 8'h00;
		end else begin
			if (any_rst) begin
				// pc and port direction on all resets
				pc_o <= PC_RESET;
				stack_pointer_o <= SP_RESET;
				port_dir_out_o <= 1'b0;
				if (pin_rst || pwr_rst) begin
					port_latch_o <= 4'h0;
				end
				if (!((pin_rst || pwr_rst) && state == RSSWK_STOP)) begin
					general_mem <= 8'h00;
					window_reg <= 4'h0;
					// shift register kept only in standby
					serial_shift_reg <= 8'h00;
				end
				data_buffer <= 4'h0;
			end else if (wr_fire && aw_q == ADDR_MEM) begin
				general_mem <= ws_q[0] ? w_q[7:0] : general_mem;
				serial_shift_reg <= ws_q[1] ? w_q[15:8] : serial_shift_reg;
				window_reg <= ws_q[2] ? w_q[19:16] : window_reg;
				data_buffer <= ws_q[2] ? w_q[23:20] : data_buffer;
				port_latch_o <= ws_q[3] ? w_q[27:24] : port_latch_o;
				port_dir_out_o <= ws_q[3] ? w_q[28] : port_dir_out_o;
			end else if (core_run_o) begin
				pc_o <= pc_o + 16'h0001;
			end
		end
	end

	// =====================================================
	// interrupts
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			irq_o <= 1'b0;
		end else begin
			if (wr_fire && aw_q == ADDR_IRQ_MASK && ws_q[0]) begin
				irq_mask <= w_q[IRQ_BITS-1:0];
			end
			irq_stat <= (irq_stat & ~((wr_fire && aw_q == ADDR_IRQ_STAT && ws_q[0]) ? w_q[IRQ_BITS-1:0] : 3'h0))
				| {wait_done, (state == RSSWK_STOP) && !any_rst && stop_cond[STOP_WAKE_BIT] && req_pending,
				stop_ignored};
			irq_o <= |(irq_stat & irq_mask);
		end
	end

endmodule
`default_nettype wire

// ---- hw/rsswk_pkg.sv ----
package rsswk_pkg;
	// =====================================================
	// register map, 32-bit aligned words
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATE    = 8'h04;
	localparam logic [7:0] ADDR_STOP     = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] ADDR_TIMER    = 8'h14;
	localparam logic [7:0] ADDR_MEM      = 8'h18;

	// =====================================================
	// field positions
	localparam int CTRL_EDGE_LO   = 0;
	localparam int CTRL_EDGE_HI   = 1;
	localparam int CTRL_PIN_IE    = 2;
	localparam int CTRL_PIN_IRQ   = 3;
	localparam int CTRL_SCK_LO    = 4;
	localparam int CTRL_SCK_HI    = 5;
	localparam int CTRL_SIO_TS    = 6;
	localparam int CTRL_SIO_IE    = 7;
	localparam int CTRL_SIO_IRQ   = 8;
	localparam int CTRL_TMR_EN    = 9;
	localparam int CTRL_TMR_IRQ   = 10;
	localparam int STOP_WAKE_BIT  = 3;

	// =====================================================
	// reset values
	localparam logic [3:0]  SP_RESET     = 4'h5;
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam logic [7:0]  TMR_CNT_RST  = 8'h00;
	localparam logic [7:0]  TMR_MOD_RST  = 8'hFF;

	// interrupt status bits
	localparam int IRQ_STOP_IGNORED = 0;
	localparam int IRQ_WOKE         = 1;
	localparam int IRQ_RESET_DONE   = 2;
	localparam int IRQ_BITS         = 3;

	typedef enum logic [2:0] {
		RSSWK_RUN  = 3'b001,
		RSSWK_STOP = 3'b010,
		RSSWK_WAIT = 3'b100
	} rsswk_state_t;

	typedef enum logic [1:0] {
		RSSWK_SRC_NONE = 2'h0,
		RSSWK_SRC_PIN  = 2'h1,
		RSSWK_SRC_PWR  = 2'h2,
		RSSWK_SRC_STK  = 2'h3
	} rsswk_src_t;
endpackage

// ---- tb/rsswk_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module rsswk_sva import rsswk_pkg::*; (
	// clock, reset, causes
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        reset_pin_n_i,
	input wire logic        power_reset_i,
	input wire logic        stack_fault_i,
	input wire logic        int_edge_i,
	input wire logic        serial_done_i,
	input wire logic        timer_tick_i,
	input wire logic        stop_exec_i,
	// core view
	input wire logic [15:0] pc_o,
	input wire logic [3:0]  stack_pointer_o,
	input wire logic        port_dir_out_o,
	input wire logic [3:0]  port_latch_o,
	input wire logic        stopped_o,
	input wire logic        core_run_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========
	// reset states
	a_pin_reset: assert property (!reset_pin_n_i |=> pc_o == PC_RESET && stack_pointer_o == SP_RESET)
		else $error("pin reset state wrong");
	a_pwr_reset: assert property (power_reset_i |=> port_latch_o == 4'h0 && !port_dir_out_o && !core_run_o)
		else $error("power reset state wrong");
	a_stack_reset: assert property (stack_fault_i |=> pc_o == PC_RESET && stack_pointer_o == SP_RESET)
		else $error("stack reset state wrong");
	a_stack_run: assert property (stack_fault_i |=> core_run_o && !port_dir_out_o)
		else $error("stack reset did not run at once");
	a_reset_wakes: assert property (stopped_o && power_reset_i |=> !stopped_o)
		else $error("power reset left stop");
	// ==========
	// stop behaviour
	a_timer_nowake: assert property (stopped_o && timer_tick_i && !int_edge_i && !serial_done_i
		&& reset_pin_n_i && !power_reset_i && !stack_fault_i && !$past(int_edge_i, 2)
		&& !$past(serial_done_i, 2) |=> stopped_o)
		else $error("timer ended stop");
	a_stop_cause: assert property ($rose(stopped_o) |-> $past(stop_exec_i) || $past(stop_exec_i, 2))
		else $error("stop without command");
	a_stop_halts: assert property (stopped_o |-> !core_run_o)
		else $error("core runs in stop");
	c_stop: cover property ($rose(stopped_o));
	c_wake: cover property ($fell(stopped_o));
	c_stack: cover property (stack_fault_i);
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
	import rsswk_pkg::*;
	logic clk_i = 0, rst_n_i = 0, reset_pin_n_i = 1, power_reset_i = 0, stack_fault_i = 0, int_pin_i = 0;
	logic int_edge_i = 0, serial_done_i = 0, timer_tick_i = 0, stop_exec_i = 0, s_axi_awvalid = 0;
	logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic stopped_o, core_run_o, irq_o, port_dir_out_o;
	logic [3:0] stop_operand_i = 4'h0, s_axi_wstrb = 4'hF, stack_pointer_o, port_latch_o;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, mv;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [15:0] pc_o;
	int err_count = 0, compares = 0, seed = 59, k, n;
	rsswk_top u_rsswk_top (.*);
	initial forever #2.5 clk_i = ~clk_i;
	// ==========
	// shared tasks
	task automatic give_verdict();
		$display("checks %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string s, logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", s, exp, got);
		end
	endtask
	task automatic tmo(int c);
		if (c >= 1000) begin
			$display("Error timeout");
			err_count++;
			give_verdict();
		end
	endtask
	task automatic wr(logic [7:0] ad, logic [31:0] dt);
		int c;
		@(posedge clk_i);
		s_axi_awaddr <= ad; s_axi_wdata <= dt;
		s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid && c < 1000);
		r = s_axi_bresp; s_axi_bready <= 0; tmo(c);
	endtask
	task automatic rd(logic [7:0] ad);
		int c;
		@(posedge clk_i);
		s_axi_araddr <= ad; s_axi_arvalid <= 1; s_axi_rready <= 1;
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid && c < 1000);
		d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0; tmo(c);
	endtask
	task automatic boot();
		int c;
		c = 0;
		while (!core_run_o && c < 1000) begin
			@(posedge clk_i);
			timer_tick_i <= ~timer_tick_i; c++;
		end
		timer_tick_i <= 0;
		tmo(c);
	endtask
	task automatic stp(logic [3:0] op);
		@(posedge clk_i);
		stop_exec_i <= 1; stop_operand_i <= op;
		@(posedge clk_i);
		stop_exec_i <= 0;
		repeat (3) @(posedge clk_i);
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1;
		n = $random(seed);
		int_pin_i <= n[0];
		rd(ADDR_STATE);
		chk("sp", d[3:0], SP_RESET);
		rd(ADDR_TIMER);
		chk("timer", d[15:0], {TMR_MOD_RST, TMR_CNT_RST});
		boot();
		wr(ADDR_STATE, $random(seed));
		chk("bresp", r, 2'h2);
		rd(8'hFC);
		chk("rresp", r, 2'h2);
		chk("rdata", d, 32'h0);
		$display("reset and map test done");
		wr(ADDR_CTRL, $random(seed) & 32'h7F7);
		mv = $random(seed);
		wr(ADDR_MEM, mv);
		@(posedge clk_i); stack_fault_i <= 1;
		@(posedge clk_i); stack_fault_i <= 0;
		repeat (2) @(posedge clk_i);
		chk("run", core_run_o, 1);
		rd(ADDR_CTRL);
		chk("ctrl stk", d & ~32'h8, 0);
		rd(ADDR_STATE);
		chk("src", d[5:4], 3);
		chk("pin stk", d[6], int_pin_i);
		rd(ADDR_MEM);
		chk("mem stk", d, {4'h0, mv[27:24], 24'h0});
		$display("stack reset test done");
		mv = $random(seed);
		wr(ADDR_MEM, mv);
		wr(ADDR_CTRL, 32'h4);
		stp(4'h0);
		chk("stop0", stopped_o, 1);
		@(posedge clk_i); int_edge_i <= 1;
		@(posedge clk_i); int_edge_i <= 0;
		repeat (3) @(posedge clk_i);
		chk("op0 hold", stopped_o, 1);
		int_pin_i <= ~int_pin_i;
		@(posedge clk_i); power_reset_i <= 1;
		@(posedge clk_i); power_reset_i <= 0;
		rd(ADDR_CTRL);
		chk("ctrl pwr", d & ~32'h8, 32'h600);
		rd(ADDR_MEM);
		chk("mem keep", d, mv & 32'h000F_FFFF);
		rd(ADDR_TIMER);
		chk("count", d[7:0], TMR_CNT_RST);
		rd(ADDR_STATE);
		chk("pin pwr", d[6], int_pin_i);
		boot();
		@(posedge clk_i); reset_pin_n_i <= 0;
		@(posedge clk_i); reset_pin_n_i <= 1;
		rd(ADDR_STATE);
		chk("src pin", d[5:4], 1);
		boot();
		$display("standby reset test done");
		for (k = 0; k < 2; k++) begin
			wr(ADDR_TIMER, 32'h1000 + (k << 8));
			wr(ADDR_CTRL, k ? 32'h2C0 : 32'h204 | ($random(seed) & 3));
			wr(ADDR_IRQ_STAT, 32'h7);
			repeat (2) @(posedge clk_i);
			stp(4'h8);
			chk("stop", stopped_o, 1);
			@(posedge clk_i); timer_tick_i <= 1;
			@(posedge clk_i); timer_tick_i <= 0;
			repeat (2) @(posedge clk_i);
			chk("tick", stopped_o, 1);
			if (k) serial_done_i <= 1;
			else int_edge_i <= 1;
			@(posedge clk_i); serial_done_i <= 0; int_edge_i <= 0;
			n = 0;
			while (stopped_o && n < 20) begin
				@(posedge clk_i);
				n++;
			end
			chk("wake", stopped_o, 0);
			boot();
		end
		$display("wake test done");
		wr(ADDR_CTRL, 32'h4);
		@(posedge clk_i); int_edge_i <= 1;
		@(posedge clk_i); int_edge_i <= 0;
		wr(ADDR_IRQ_STAT, 32'h7);
		stp(4'h8);
		chk("ignored", stopped_o, 0);
		rd(ADDR_IRQ_STAT);
		chk("stat", d[0], 1);
		wr(ADDR_IRQ_MASK, 32'h0);
		@(posedge clk_i);
		chk("irq off", irq_o, 0);
		wr(ADDR_IRQ_MASK, 32'h7);
		@(posedge clk_i);
		chk("irq mask", irq_o, 1);
		wr(ADDR_IRQ_STAT, 32'h7);
		repeat (2) @(posedge clk_i);
		chk("irq clr", irq_o, 0);
		$display("ignored stop test done");
		give_verdict();
	end
endmodule
bind rsswk_top rsswk_sva u_rsswk_sva (.*);
`default_nettype wire
